// *** hw/scfr_pkg.sv ***
/*
 * Constants, types and register map of the strap configuration loader
 * and fault reporter.
 * Assumes one 25 MHz clock and strap steps already resolved to 4 bits.
 */
// Behaviour
// - Stand-alone: serial pins act as straps two, three
// - Each strap resolves to step 0 to 15
// - Strap one sets spread, sync direction; in stand-alone also frequency, sync enable
// - Strap two loads gain bits three to zero
// - Strap three steps 4-7, 12-15 set gain MSB
// - Strap three step modulo four picks current limit
// - Strap three steps 8-15 enable sixty-minute hold
// - Hold request ignored on variant without hold
// - Fault output held while any fault present
// - Reading an error register clears it
// - Persisting fault sets its error bit again
// - Enable registers gate errors onto interrupt pin
// - Error read releases interrupt; persisting fault reasserts
// - Fault output deglitched and blanked at start-up
// - Fault output open-drain and active low
`default_nettype none
package scfr_pkg;
    localparam int CLK_KHZ = 25000;
    localparam int DEGLITCH_US = 16;
    localparam int DEGLITCH_CYC = (DEGLITCH_US * CLK_KHZ + 999) / 1000;
    localparam int BLANK_MS = 4;
    localparam int BLANK_CYC = BLANK_MS * CLK_KHZ;
    localparam int HOLD_MIN = 60;
    localparam logic [5:0] HOLD_MINUTES = 6'(HOLD_MIN);

    localparam int STEP_W = 4;
    localparam int ERR_W = 9;
    localparam int ERR1_W = 8;
    localparam int IN_OV_BIT = 8;
    localparam int EV_W = 3;
    localparam int EV_CFG = 0;
    localparam int EV_FAULT = 1;
    localparam int EV_ERR = 2;
    localparam int SPREAD_OFF_BIT = 3;
    localparam int SYNC_OUT_BIT = 2;
    localparam int GAIN_MSB_BIT = 2;
    localparam int HOLD_STEP_BIT = 3;
    localparam logic [1:0] NO_SYNC_TOP = 2'h0;
    localparam logic [3:0] STEP_LAST = 4'hF;

    localparam logic [11:0] FSW_2200 = 12'h898;
    localparam logic [11:0] FSW_488 = 12'h1E8;
    localparam logic [11:0] FSW_350 = 12'h15E;
    localparam logic [11:0] FSW_310 = 12'h136;
    localparam logic [11:0] FSW_210 = 12'h0D2;

    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_STRAP = 8'h04;
    localparam logic [7:0] REG_ERR1 = 8'h08;
    localparam logic [7:0] REG_ERR2 = 8'h0C;
    localparam logic [7:0] REG_EN_LOW = 8'h10;
    localparam logic [7:0] REG_EN_HIGH = 8'h14;
    localparam logic [7:0] REG_IRQ_STAT = 8'h18;
    localparam logic [7:0] REG_IRQ_MASK = 8'h1C;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    typedef struct packed {
        logic spread_en;
        logic sync_en;
        logic sync_is_out;
        logic [11:0] fsw_khz;
        logic [4:0] gain;
        logic [1:0] usb_current_limit_sel;
        logic hold_en;
        logic [5:0] hold_min;
    } scfr_cfg_t;
    localparam scfr_cfg_t CFG_RST = '0;

    typedef enum logic [1:0] {
        LD_WAIT = 2'b00,
        LD_SAMPLE = 2'b01,
        LD_DONE = 2'b10
    } scfr_load_t;
endpackage
`default_nettype wire

// *** hw/scfr_top.sv ***
/*
 * Strap configuration loader with fault pin, error registers and APB
 * register access.
 * Assumes strap steps and fault conditions arrive synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module scfr_top #(
    parameter int BLANK_CYCLES = scfr_pkg::BLANK_CYC
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Straps and variant
    input wire logic [3:0] strap_pin_one_in,
    input wire logic [3:0] strap_pin_two_in,
    input wire logic [3:0] strap_pin_three_in,
    input wire logic standalone_variant_in,
    input wire logic hold_capable_in,
    // Fault conditions
    input wire logic [8:0] fault_cond_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Configuration
    output scfr_pkg::scfr_cfg_t cfg_out,
    output logic cfg_valid_out,
    // Pins and interrupt
    output logic fault_pin_o_out,
    output logic fault_pin_oe_n_out,
    output logic int_n_out,
    output logic irq_out
);
    import scfr_pkg::*;

    scfr_load_t ld_state_r;
    scfr_load_t ld_state_nxt;
    scfr_cfg_t cfg_r;
    scfr_cfg_t cfg_nxt;
    logic [3:0] step_one_r;
    logic [3:0] step_two_r;
    logic [3:0] step_three_r;
    logic standalone_r;
    logic [ERR_W-1:0] err_r;
    logic [ERR1_W-1:0] en_low_r;
    logic en_high_r;
    logic [EV_W-1:0] irq_stat_r;
    logic [EV_W-1:0] irq_mask_r;
    logic [31:0] blank_cnt_r;
    logic [15:0] dg_cnt_r;
    logic fault_oe_n_r;
    logic int_n_r;
    logic irq_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic cfg_valid_r;

    // Bus decode
    wire setup = psel_in & ~penable_in & ~pready_r;
    wire acc_done = psel_in & penable_in & pready_r;
    wire wr_done = acc_done & pwrite_in;
    wire hit_cfg = paddr_in == REG_CFG;
    wire hit_strap = paddr_in == REG_STRAP;
    wire hit_err1 = paddr_in == REG_ERR1;
    wire hit_err2 = paddr_in == REG_ERR2;
    wire hit_en_low = paddr_in == REG_EN_LOW;
    wire hit_en_high = paddr_in == REG_EN_HIGH;
    wire hit_stat = paddr_in == REG_IRQ_STAT;
    wire hit_mask = paddr_in == REG_IRQ_MASK;
    wire hit_any = hit_cfg | hit_strap | hit_err1 | hit_err2 |
        hit_en_low | hit_en_high | hit_stat | hit_mask;
    wire rd_err1 = acc_done & ~pwrite_in & hit_err1;
    wire rd_err2 = acc_done & ~pwrite_in & hit_err2;

    wire [31:0] rdata_nxt =
        hit_cfg ? {3'h0, cfg_r} :
        hit_strap ? {19'h0, standalone_r, step_three_r, step_two_r,
            step_one_r} :
        hit_err1 ? {24'h0, err_r[ERR1_W-1:0]} :
        hit_err2 ? {31'h0, err_r[IN_OV_BIT]} :
        hit_en_low ? {24'h0, en_low_r} :
        hit_en_high ? {31'h0, en_high_r} :
        hit_stat ? {29'h0, irq_stat_r} :
        hit_mask ? {29'h0, irq_mask_r} : RDATA_RST;

    // Load sequencing
    wire load_now = ld_state_r == LD_SAMPLE;
    always_comb begin
        ld_state_nxt = ld_state_r;
        unique case (ld_state_r)
            LD_WAIT: ld_state_nxt = LD_SAMPLE;
            LD_SAMPLE: ld_state_nxt = LD_DONE;
            LD_DONE: ld_state_nxt = LD_DONE;
            default: ld_state_nxt = LD_WAIT;
        endcase
    end

    // Strap decode from the captured steps
    wire [1:0] s1_low = step_one_r[1:0];
    wire [11:0] fsw_sel =
        (step_one_r == STEP_LAST) ? FSW_210 :
        (s1_low == 2'h0) ? FSW_2200 :
        (s1_low == 2'h1) ? FSW_488 :
        (s1_low == 2'h2) ? FSW_350 : FSW_310;
    wire s1_no_sync = step_one_r[3:2] == NO_SYNC_TOP;
    wire hold_req = step_three_r[HOLD_STEP_BIT] & hold_capable_in;
    localparam logic [11:0] FSW_RESET_SEL = FSW_2200;
    always_comb begin
        cfg_nxt = CFG_RST;
        cfg_nxt.spread_en = ~step_one_r[SPREAD_OFF_BIT];
        cfg_nxt.sync_is_out = step_one_r[SYNC_OUT_BIT];
        cfg_nxt.sync_en = ~(standalone_r & s1_no_sync);
        cfg_nxt.fsw_khz = standalone_r ? fsw_sel : FSW_RESET_SEL;
        if (standalone_r) begin
            cfg_nxt.gain[3:0] = step_two_r;
            cfg_nxt.gain[4] = step_three_r[GAIN_MSB_BIT];
            cfg_nxt.usb_current_limit_sel = step_three_r[1:0];
            cfg_nxt.hold_en = hold_req;
            cfg_nxt.hold_min = hold_req ? HOLD_MINUTES : 6'h00;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (ld_state_r == LD_WAIT) begin
            step_one_r <= strap_pin_one_in;
            step_two_r <= strap_pin_two_in;
            step_three_r <= strap_pin_three_in;
            standalone_r <= standalone_variant_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ld_state_r <= LD_WAIT;
            cfg_r <= CFG_RST;
            cfg_valid_r <= 1'b0;
        end else begin
            ld_state_r <= ld_state_nxt;
            cfg_valid_r <= ld_state_nxt == LD_DONE;
            if (load_now) begin
                cfg_r <= cfg_nxt;
            end
        end
    end

    // Error bits; the read clear wins so the interrupt can drop
    genvar gi;
    generate
        for (gi = 0; gi < ERR_W; gi++) begin : g_err
            wire clr = (gi == IN_OV_BIT) ? rd_err2 : rd_err1;
            always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    err_r[gi] <= 1'b0;
                end else if (clr) begin
                    err_r[gi] <= 1'b0;
                end else begin
                    err_r[gi] <= err_r[gi] | fault_cond_in[gi];
                end
            end
        end
    endgenerate

    wire [ERR_W-1:0] int_en = {en_high_r, en_low_r};
    wire int_n_nxt = ~|(err_r & int_en);

    // Fault path
    wire any_fault = |fault_cond_in;
    wire blank_act = blank_cnt_r != 32'h0;
    wire [15:0] dg_full = 16'(DEGLITCH_CYC);
    wire dg_ok = dg_cnt_r == dg_full;
    wire fault_oe_n_nxt = ~(any_fault & dg_ok);

    // Events for the sticky status
    wire [EV_W-1:0] ev;
    assign ev[EV_CFG] = load_now;
    assign ev[EV_FAULT] = fault_oe_n_r & ~fault_oe_n_nxt;
    assign ev[EV_ERR] = |(fault_cond_in & ~err_r);
    wire [EV_W-1:0] w1c = (wr_done & hit_stat) ? pwdata_in[EV_W-1:0] :
        {EV_W{1'b0}};

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            blank_cnt_r <= 32'h0;
            dg_cnt_r <= 16'h0;
            fault_oe_n_r <= 1'b1;
        end else begin
            if (load_now) begin
                blank_cnt_r <= 32'(BLANK_CYCLES);
            end else if (blank_act) begin
                blank_cnt_r <= blank_cnt_r - 32'h1;
            end
            if (!any_fault || blank_act || ld_state_r != LD_DONE) begin
                dg_cnt_r <= 16'h0;
            end else if (!dg_ok) begin
                dg_cnt_r <= dg_cnt_r + 16'h1;
            end
            fault_oe_n_r <= fault_oe_n_nxt;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            en_low_r <= 8'h00;
            en_high_r <= 1'b0;
            irq_mask_r <= 3'h0;
            irq_stat_r <= 3'h0;
            int_n_r <= 1'b1;
            irq_r <= 1'b0;
        end else begin
            if (wr_done && hit_en_low) begin
                en_low_r <= pwdata_in[ERR1_W-1:0];
            end
            if (wr_done && hit_en_high) begin
                en_high_r <= pwdata_in[0];
            end
            if (wr_done && hit_mask) begin
                irq_mask_r <= pwdata_in[EV_W-1:0];
            end
            // New events win over a write-one clear
            irq_stat_r <= (irq_stat_r & ~w1c) | ev;
            int_n_r <= int_n_nxt;
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    // No wait state; read data is registered on a flip-flop during setup
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prdata_r <= RDATA_RST;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            if (setup) begin
                prdata_r <= pwrite_in ? RDATA_RST : rdata_nxt;
                pslverr_r <= ~hit_any;
            end else if (acc_done) begin
                pslverr_r <= 1'b0;
            end
        end
    end

    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign cfg_out = cfg_r;
    assign cfg_valid_out = cfg_valid_r;
    assign fault_pin_o_out = 1'b0;
    assign fault_pin_oe_n_out = fault_oe_n_r;
    assign int_n_out = int_n_r;
    assign irq_out = irq_r;

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    a_cfg_held_stable: assert property (
        cfg_valid_out && $past(cfg_valid_out) |-> $stable(cfg_r))
        else $error("configuration changed after load");
    a_gain_low_bits: assert property (
        load_now && standalone_r |=> cfg_r.gain[3:0] == step_two_r)
        else $error("gain low bits differ from strap two");
    a_gain_msb_map: assert property (
        load_now && standalone_r |=>
        cfg_r.gain[4] == (step_three_r inside {[4:7], [12:15]}))
        else $error("gain msb wrong for strap three");
    a_usb_current_limit_sel_map: assert property (
        load_now && standalone_r |=>
        cfg_r.usb_current_limit_sel == step_three_r % 4)
        else $error("current limit code wrong");
    a_hold_needs_cap: assert property (
        load_now && !hold_capable_in |=> !cfg_r.hold_en)
        else $error("hold enabled on variant without hold");
    a_fault_held: assert property (
        !fault_pin_oe_n_out && any_fault |=> !fault_pin_oe_n_out)
        else $error("fault pin released while fault present");
    a_fault_release: assert property (
        !any_fault |=> fault_pin_oe_n_out)
        else $error("fault pin held with no fault");
    a_deglitch_wait: assert property (
        $fell(fault_pin_oe_n_out) |-> $past(any_fault, 2) &&
        $past(dg_cnt_r) == dg_full && !$past(blank_act))
        else $error("fault pin asserted before deglitch time");
    a_err_read_clr: assert property (
        rd_err1 |=> err_r[ERR1_W-1:0] == 8'h00)
        else $error("error register not cleared by read");
    a_err_reassert: assert property (
        rd_err1 ##1 fault_cond_in[0] |=> err_r[0])
        else $error("persisting fault did not set again");
    a_int_release: assert property (
        rd_err1 && !en_high_r |=> ##1 int_n_out)
        else $error("interrupt not released by error read");
    a_int_masked: assert property (
        int_en == '0 ##1 int_en == '0 |=> int_n_out)
        else $error("disabled error drove interrupt");

    a_spread_map: assert property (
        load_now |=> cfg_r.spread_en == !step_one_r[SPREAD_OFF_BIT])
        else $error("spread enable wrong for strap one");
    a_sync_dir_map: assert property (
        load_now |=> cfg_r.sync_is_out == step_one_r[SYNC_OUT_BIT])
        else $error("sync direction wrong for strap one");
    a_sync_unused: assert property (
        load_now && standalone_r && step_one_r[3:2] == NO_SYNC_TOP |=>
        !cfg_r.sync_en)
        else $error("sync enabled for a step without sync");
    a_fsw_last_step: assert property (
        load_now && standalone_r && step_one_r == STEP_LAST |=>
        cfg_r.fsw_khz == FSW_210)
        else $error("last strap one step gives wrong frequency");
    a_hold_steps: assert property (
        load_now && standalone_r && hold_capable_in |=>
        cfg_r.hold_en == step_three_r[HOLD_STEP_BIT])
        else $error("hold enable wrong for strap three");
    a_hold_minutes: assert property (
        cfg_r.hold_en |-> cfg_r.hold_min == HOLD_MINUTES)
        else $error("hold duration wrong");
    a_strap_capture: assert property (
        ld_state_r == LD_WAIT |=>
        step_two_r == $past(strap_pin_two_in) &&
        step_three_r == $past(strap_pin_three_in))
        else $error("serial pins not taken as straps two and three");
    a_straps_frozen: assert property (
        cfg_valid_out |=>
        $stable({standalone_r, step_three_r, step_two_r, step_one_r}))
        else $error("strap steps changed after load");
    a_fault_assert: assert property (
        any_fault && dg_ok |=> !fault_pin_oe_n_out)
        else $error("fault pin not asserted after deglitch");
    a_blank_quiet: assert property (
        blank_act |=> fault_pin_oe_n_out)
        else $error("fault pin asserted during blanking");
    a_load_quiet: assert property (
        !cfg_valid_out |=> fault_pin_oe_n_out)
        else $error("fault pin asserted before load");
    a_err_set: assert property (
        fault_cond_in[0] && !rd_err1 |=> err_r[0])
        else $error("fault condition did not set its error bit");
    a_err2_set: assert property (
        fault_cond_in[IN_OV_BIT] && !rd_err2 |=> err_r[IN_OV_BIT])
        else $error("overvoltage condition did not set its error bit");
    a_err_sticky: assert property (
        err_r[0] && !rd_err1 |=> err_r[0])
        else $error("error bit lost without a read");
    a_err2_sticky: assert property (
        err_r[IN_OV_BIT] && !rd_err2 |=> err_r[IN_OV_BIT])
        else $error("overvoltage error bit lost without a read");
    a_err2_read_clr: assert property (
        rd_err2 |=> !err_r[IN_OV_BIT])
        else $error("second error register not cleared by read");
    a_int_follows: assert property (
        (err_r & int_en) != '0 |=> !int_n_out)
        else $error("enabled error did not drive interrupt");
    a_int_reassert: assert property (
        rd_err1 ##1 (fault_cond_in[0] && en_low_r[0]) |=> ##1 !int_n_out)
        else $error("interrupt did not reassert for persisting fault");
endmodule
`default_nettype wire

// *** testbench/scfr_hub_model.sv ***
/*
 * Hub controller overcurrent input model, sensing the pulled-up fault wire.
 * Assumes the bench resolves the open-drain wire with a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module scfr_hub_model (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Fault wire
    input wire logic fault_wire_n_in,
    // Sensed overcurrent
    output logic oc_seen_out
);
    logic [1:0] sync_r;
    // Active-low wire sense
    // Two stages, since a real hub sees the wire asynchronously
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync_r <= 2'h0;
        end else begin
            sync_r <= {sync_r[0], ~fault_wire_n_in};
        end
    end
    assign oc_seen_out = sync_r[1];
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
/*
 * Self-checking bench: strap decode, fault pin, error and interrupt regs.
 * Assumes scfr_pkg, scfr_top and scfr_hub_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import scfr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] s1 = 4'h0, s2 = 4'h0, s3 = 4'h0;
    logic sa = 1'b1, hc = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [8:0] fc = 9'h000;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, cfg_v, f_o, f_oe_n, int_n, irq, oc, er;
    wire fault_wire_n = f_oe_n ? 1'b1 : f_o;
    scfr_cfg_t cfg, e;
    int err_count = 0, n_tests = 0, k, b;

    scfr_top #(.BLANK_CYCLES(20)) dut (.ref_clk_in(clk), .reset_n_in(rst_n),
        .strap_pin_one_in(s1), .strap_pin_two_in(s2),
        .strap_pin_three_in(s3), .standalone_variant_in(sa),
        .hold_capable_in(hc), .fault_cond_in(fc), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .cfg_out(cfg), .cfg_valid_out(cfg_v),
        .fault_pin_o_out(f_o), .fault_pin_oe_n_out(f_oe_n),
        .int_n_out(int_n), .irq_out(irq));
    scfr_hub_model hub (.ref_clk_in(clk), .reset_n_in(rst_n),
        .fault_wire_n_in(fault_wire_n), .oc_seen_out(oc));

    initial begin
        forever #20 clk = ~clk;
    end

    function automatic scfr_cfg_t exp_cfg(input logic [3:0] a, g, c,
                                          input logic fa, fh);
        scfr_cfg_t x;
        x = CFG_RST;
        x.spread_en = ~a[3];
        x.sync_is_out = a[2];
        x.sync_en = ~fa | (a[3:2] != NO_SYNC_TOP);
        x.fsw_khz = FSW_2200;
        if (fa) begin
            case (a[1:0])
                2'h1: x.fsw_khz = FSW_488;
                2'h2: x.fsw_khz = FSW_350;
                2'h3: x.fsw_khz = (a == STEP_LAST) ? FSW_210 : FSW_310;
                default: x.fsw_khz = FSW_2200;
            endcase
            x.gain = {c[GAIN_MSB_BIT], g};
            x.usb_current_limit_sel = c[1:0];
            // Hold needs a capable variant and strap three bit three
            x.hold_en = fh & c[HOLD_STEP_BIT];
            if (x.hold_en) begin
                x.hold_min = HOLD_MINUTES;
            end
        end
        return x;
    endfunction

    task automatic summarize;
        if (err_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            err_count++;
            summarize();
        end
        rdv = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] x,
                       input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, x, rdv);
    endtask

    task automatic boot;
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(3);
    endtask

    initial begin
        void'($urandom(82614));
        for (k = 0; k < 24; k++) begin
            @(posedge clk);
            s1 <= (k < 16) ? 4'(k) : 4'($urandom);
            s2 <= (k < 16) ? 4'(15 - k) : 4'($urandom);
            s3 <= (k < 16) ? 4'(k) : 4'($urandom);
            sa <= (k < 16) ? 1'b1 : 1'($urandom);
            hc <= (k < 16) ? 1'(k) : 1'($urandom);
            boot();
            e = exp_cfg(s1, s2, s3, sa, hc);
            chk("cfg_valid", 32'h1, 32'(cfg_v));
            chk("cfg_osc", 32'(e[28:14]), 32'(cfg[28:14]));
            chk("cfg_gain", 32'(e.gain), 32'(cfg.gain));
            chk("cfg_usb_current_limit_sel", 32'(e[8:7]), 32'(cfg[8:7]));
            chk("cfg_hold", 32'(e[6:0]), 32'(cfg[6:0]));
            rdc(REG_CFG, 32'(e), "cfg_reg");
            rdc(REG_STRAP, {19'h0, sa, s3, s2, s1}, "straps");
            s1 <= ~s1;
            s3 <= ~s3;
            cyc(3);
            chk("cfg_held", 32'(e), 32'(cfg));
        end
        fc <= 9'h004;
        boot();
        cyc(407);
        chk("blank_pin", 32'h1, 32'(f_oe_n));
        cyc(20);
        chk("blank_end", 32'h0, 32'(f_oe_n));
        fc <= 9'h000;
        cyc(30);
        fc <= 9'h001;
        cyc(300);
        fc <= 9'h000;
        cyc(3);
        chk("glitch_pin", 32'h1, 32'(f_oe_n));
        fc <= 9'h004;
        cyc(405);
        chk("fault_pin", 32'h0, 32'(f_oe_n));
        cyc(3);
        chk("hub_oc", 32'h1, 32'(oc));
        cyc(200);
        chk("fault_held", 32'h0, 32'(f_oe_n));
        fc <= 9'h000;
        cyc(3);
        chk("fault_gone", 32'h1, 32'(f_oe_n));
        rdc(REG_ERR1, 32'h5, "err1");
        rdc(REG_ERR1, 32'h0, "err1_clr");
        apb(1'b1, REG_EN_LOW, 32'hFF);
        apb(1'b1, REG_EN_HIGH, 32'h1);
        for (k = 0; k < 6; k++) begin
            b = (k == 0) ? 8 : $urandom_range(0, 8);
            fc <= 9'(1 << b);
            paddr <= (b == 8) ? REG_ERR2 : REG_ERR1;
            cyc(4);
            chk("int_n_on", 32'h0, 32'(int_n));
            rdc(paddr, (b == 8) ? 32'h1 : 32'(1 << b), "err_set");
            cyc(2);
            chk("int_n_release", 32'h1, 32'(int_n));
            cyc(2);
            chk("int_n_again", 32'h0, 32'(int_n));
            fc <= 9'h000;
            rdc(paddr, (b == 8) ? 32'h1 : 32'(1 << b), "err_again");
            cyc(3);
            chk("int_n_off", 32'h1, 32'(int_n));
            rdc(paddr, 32'h0, "err_empty");
        end
        apb(1'b1, REG_EN_LOW, 32'h0);
        apb(1'b1, REG_EN_HIGH, 32'h0);
        fc <= 9'h1FF;
        cyc(10);
        chk("int_n_masked", 32'h1, 32'(int_n));
        fc <= 9'h000;
        rdc(REG_IRQ_STAT, 32'h7, "irq_stat");
        apb(1'b1, REG_IRQ_MASK, 32'h1);
        cyc(2);
        chk("irq_on", 32'h1, 32'(irq));
        apb(1'b1, REG_IRQ_STAT, 32'h7);
        cyc(2);
        chk("irq_off", 32'h0, 32'(irq));
        rdc(REG_IRQ_STAT, 32'h0, "irq_stat_clr");
        rdc(8'h20, 32'h0, "unmapped_data");
        chk("unmapped_err", 32'h1, 32'(er));
        summarize();
    end
endmodule
`default_nettype wire
